// [verilog/gpdt_defs.svh]
`ifndef GPDT_DEFS_SVH
`define GPDT_DEFS_SVH

// Register indices; byte address is four times the index
`define GPDT_RELOAD_IDX 8'ha0
`define GPDT_ISRC_IDX 8'ha2
`define GPDT_CTL_IDX 8'ha3
`define GPDT_IMASK_IDX 8'ha5

`define GPDT_RELOAD_RST 16'hffff
`define GPDT_ISRC_RST 1'b0
`define GPDT_IMASK_RST 1'b0

`define GPDT_UFLOW_BIT 0
`define GPDT_CTL_ENABLE_BIT 0
`define GPDT_CTL_RESET_BIT 1
`define GPDT_CTL_STOP_BIT 2
`define GPDT_CTL_STATUS_BIT 7

`define GPDT_CLK_PERIOD_NS 8
`define GPDT_TICK_TIME_US 1000
`define GPDT_SETTLE_TIME_US 200
`define GPDT_TICK_CYCLES ((`GPDT_TICK_TIME_US * 1000) / `GPDT_CLK_PERIOD_NS)
`define GPDT_SETTLE_CYCLES \
	((`GPDT_SETTLE_TIME_US * 1000 + `GPDT_CLK_PERIOD_NS - 1) / `GPDT_CLK_PERIOD_NS)

`endif

// [verilog/gpdt_pkg.sv]
package gpdt_pkg;
	typedef enum logic [1:0] {
		GPDT_IDLE,
		GPDT_RUN,
		GPDT_RESETTING,
		GPDT_HALTING
	} gpdt_state_t;
endpackage

// [verilog/gpdt_time_if.sv]
`timescale 1ns/1ns
interface gpdt_time_if;
	logic run;
	logic tick;
	logic settle_start;
	logic settle_done;
	modport core (output run, output settle_start, input tick, input settle_done);
	modport ticker (input run, output tick);
	modport settler (input settle_start, output settle_done);
endinterface

// [verilog/gpdt_tick.sv]
`timescale 1ns/1ns
module gpdt_tick
	import gpdt_pkg::*;
#(
	parameter int TICK_CYCLES = 125000
)
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	gpdt_time_if.ticker tif
);
	localparam int CW = $clog2(TICK_CYCLES);

	initial
	begin
		if (TICK_CYCLES < 2)
			$error("gpdt_tick: TICK_CYCLES must be at least 2");
	end

	logic [CW-1:0] cnt_reg;
	logic tick_reg;
	wire last = (cnt_reg == CW'(TICK_CYCLES - 1));

	// Prescaler restarts whenever counting pauses, so every interval is a whole millisecond
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= (!tif.run || last) ? '0 : cnt_reg + CW'(1);
			tick_reg <= tif.run && last;
		end
	end

	assign tif.tick = tick_reg;
endmodule

// [verilog/gpdt_settle.sv]
`timescale 1ns/1ns
module gpdt_settle
	import gpdt_pkg::*;
#(
	parameter int SETTLE_CYCLES = 25000
)
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	gpdt_time_if.settler tif
);
	localparam int CW = $clog2(SETTLE_CYCLES + 1);

	initial
	begin
		if (SETTLE_CYCLES < 1)
			$error("gpdt_settle: SETTLE_CYCLES must be at least 1");
	end

	logic [CW-1:0] cnt_reg;
	logic busy_reg;
	logic done_reg;
	wire last = busy_reg && (cnt_reg == CW'(SETTLE_CYCLES - 1));

	// A new start restarts the wait in full
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= (tif.settle_start || last) ? '0 : (busy_reg ? cnt_reg + CW'(1) : cnt_reg);
			busy_reg <= tif.settle_start || (busy_reg && !last);
			done_reg <= last && !tif.settle_start;
		end
	end

	assign tif.settle_done = done_reg;
endmodule

// [verilog/gpdt_timer.sv]
// Chosen here: register access over APB.
`timescale 1ns/1ns
`include "gpdt_defs.svh"
module gpdt_timer
	import gpdt_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int TICK_CYCLES = `GPDT_TICK_CYCLES,
	parameter int SETTLE_CYCLES = `GPDT_SETTLE_CYCLES
)
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic timer_interrupt_indication_out,
	output logic irq_out
);
	initial
	begin
		if (ADDR_W < 10 || ADDR_W > 32)
			$error("gpdt_timer: ADDR_W must lie in 10..32");
	end

	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = ADDR_W'({idx, 2'b00});
	endfunction

	gpdt_time_if tif();

	gpdt_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.tif(tif.ticker)
	);

	gpdt_settle #(
		.SETTLE_CYCLES(SETTLE_CYCLES)
	) u_settle (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.tif(tif.settler)
	);

	gpdt_state_t state_reg;
	gpdt_state_t state_next;
	logic [15:0] reload_reg;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic enable_reg;
	logic enable_next;
	logic stop_reg;
	logic uflow_reg;
	logic mask_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rdata;

	// Bus decode
	wire setup = psel_in && !penable_in;
	wire access = psel_in && penable_in;
	wire sel_reload = (paddr_in == reg_addr(`GPDT_RELOAD_IDX));
	wire sel_isrc = (paddr_in == reg_addr(`GPDT_ISRC_IDX));
	wire sel_ctl = (paddr_in == reg_addr(`GPDT_CTL_IDX));
	wire sel_mask = (paddr_in == reg_addr(`GPDT_IMASK_IDX));
	wire mapped = sel_reload || sel_isrc || sel_ctl || sel_mask;
	wire wr = access && pwrite_in;
	wire wr_reload = wr && sel_reload;
	wire wr_isrc = wr && sel_isrc;
	wire wr_ctl = wr && sel_ctl;
	wire wr_mask = wr && sel_mask;
	wire wr_reset = wr_ctl && pwdata_in[`GPDT_CTL_RESET_BIT];

	// Timer events
	wire running = (state_reg == GPDT_RUN);
	wire resetting = (state_reg == GPDT_RESETTING);
	wire status = running || (state_reg == GPDT_HALTING);
	wire step = running && tif.tick;
	// A zero count is treated like one, so a tick on it never wraps through all ones
	wire underflow = step && (count_reg <= 16'h0001);
	wire stop_uflow = underflow && stop_reg;
	// Flag waits for the halt to settle when stopping, else sets at once
	wire uflow_set = (state_reg == GPDT_HALTING && tif.settle_done)
		|| (underflow && !stop_reg);
	wire uflow_clr = wr_isrc && pwdata_in[`GPDT_UFLOW_BIT];
	wire uflow_next = uflow_set || (uflow_reg && !uflow_clr);

	assign tif.run = running;
	// The settle wait models the slow propagation of reset and halt
	assign tif.settle_start = wr_reset || stop_uflow;

	always_comb
	begin
		state_next = state_reg;
		if (wr_reset)
			state_next = GPDT_RESETTING;
		else
		begin
			case (state_reg)
				GPDT_IDLE:
				begin
					if (enable_reg)
						state_next = GPDT_RUN;
				end
				GPDT_RUN:
				begin
					if (stop_uflow)
						state_next = GPDT_HALTING;
					else if (!enable_reg)
						state_next = GPDT_IDLE;
				end
				GPDT_RESETTING:
				begin
					if (tif.settle_done)
						state_next = GPDT_IDLE;
				end
				GPDT_HALTING:
				begin
					if (tif.settle_done)
						state_next = GPDT_IDLE;
				end
				default:
					state_next = GPDT_IDLE;
			endcase
		end
	end

	always_comb
	begin
		count_next = count_reg;
		if (wr_reset)
			count_next = reload_reg;
		// An empty count (after reset or a halt) starts from the reload value
		else if (state_reg == GPDT_IDLE && enable_reg && count_reg == 16'h0000)
			count_next = reload_reg;
		else if (stop_uflow)
			count_next = 16'h0000;
		else if (underflow)
			count_next = reload_reg;
		else if (step)
			count_next = count_reg - 16'h0001;
	end

	// Hardware clear on underflow with stop set wins over a software write in the same cycle
	always_comb
	begin
		enable_next = enable_reg;
		if (wr_ctl)
			enable_next = pwdata_in[`GPDT_CTL_ENABLE_BIT];
		if (stop_uflow)
			enable_next = 1'b0;
	end

	// Read data is latched in the setup phase and stands through the access phase
	always_comb
	begin
		rdata = 32'h0000_0000;
		if (sel_reload)
			rdata[15:0] = reload_reg;
		else if (sel_isrc)
			rdata[`GPDT_UFLOW_BIT] = uflow_reg;
		else if (sel_mask)
			rdata[`GPDT_UFLOW_BIT] = mask_reg;
		else if (sel_ctl)
		begin
			rdata[`GPDT_CTL_STATUS_BIT] = status;
			rdata[`GPDT_CTL_STOP_BIT] = stop_reg;
			rdata[`GPDT_CTL_RESET_BIT] = resetting;
			rdata[`GPDT_CTL_ENABLE_BIT] = enable_reg;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_reg <= GPDT_IDLE;
			count_reg <= 16'h0000;
			enable_reg <= 1'b0;
			uflow_reg <= `GPDT_ISRC_RST;
		end
		else
		begin
			state_reg <= state_next;
			count_reg <= count_next;
			enable_reg <= enable_next;
			uflow_reg <= uflow_next;
		end
	end

	// Reload is not guarded during reset: software keeps off it until bit 1 clears
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			reload_reg <= `GPDT_RELOAD_RST;
			stop_reg <= 1'b0;
			mask_reg <= `GPDT_IMASK_RST;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			if (wr_reload)
				reload_reg <= pwdata_in[15:0];
			if (wr_ctl)
				stop_reg <= pwdata_in[`GPDT_CTL_STOP_BIT];
			if (wr_mask)
				mask_reg <= pwdata_in[`GPDT_UFLOW_BIT];
			if (setup)
				prdata_reg <= rdata;
		end
	end

	assign prdata_out = prdata_reg;
	assign pready_out = 1'b1;
	assign pslverr_out = access && !mapped;
	assign timer_interrupt_indication_out = uflow_reg;
	assign irq_out = uflow_reg && mask_reg;
endmodule

// [bench/gpdt_timer_sva.sv]
`timescale 1ns/1ns
`include "gpdt_defs.svh"
module gpdt_timer_sva
	import gpdt_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic timer_interrupt_indication_out,
	input wire logic irq_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);
	wire logic acc = psel_in && penable_in;
	wire logic at_rl = paddr_in == ADDR_W'(4 * `GPDT_RELOAD_IDX);
	wire logic at_is = paddr_in == ADDR_W'(4 * `GPDT_ISRC_IDX);
	wire logic at_ct = paddr_in == ADDR_W'(4 * `GPDT_CTL_IDX);
	wire logic at_mk = paddr_in == ADDR_W'(4 * `GPDT_IMASK_IDX);
	wire logic hit = at_rl || at_is || at_ct || at_mk;
	wire logic wr = acc && pwrite_in;
	// Read data is latched at the setup edge, so it is judged in the access cycle
	sequence rd_s(logic sel);
		psel_in && !penable_in && !pwrite_in && sel ##1 acc;
	endsequence
	property flag_drop_p;
		$fell(timer_interrupt_indication_out) |-> $past(wr && at_is && pwdata_in[0]);
	endproperty
	property irq_drop_p;
		$fell(irq_out) |-> $past(wr && (at_is || at_mk));
	endproperty
	ready_seen_a: assert property (acc |-> pready_out)
		else $error("ready missing in access");
	miss_err_a: assert property (acc && !hit |-> pslverr_out)
		else $error("no error on unmapped access");
	hit_ok_a: assert property (acc && hit |-> !pslverr_out)
		else $error("error on mapped access");
	err_phase_a: assert property (pslverr_out |-> acc)
		else $error("error outside access");
	irq_has_flag_a: assert property (irq_out |-> timer_interrupt_indication_out)
		else $error("irq without flag");
	flag_drop_a: assert property (flag_drop_p)
		else $error("flag fell without clear");
	irq_drop_a: assert property (irq_drop_p)
		else $error("irq fell without write");
	miss_zero_a: assert property (rd_s(!hit) |-> prdata_out == 32'h0)
		else $error("unmapped read not zero");
	ctl_read_a: assert property (rd_s(at_ct) |-> prdata_out[31:8] == 24'h0 &&
		prdata_out[6:3] == 4'h0 && !(prdata_out[7] && prdata_out[1]))
		else $error("bad control read");
	isrc_read_a: assert property (rd_s(at_is) |-> prdata_out[31:1] == 31'h0)
		else $error("bad source read");
	reload_read_a: assert property (rd_s(at_rl) |-> prdata_out[31:16] == 16'h0)
		else $error("bad reload read");
endmodule
bind gpdt_timer gpdt_timer_sva #(
	.ADDR_W(ADDR_W)
) gpdt_timer_sva_i (
	.clk_sys_in(clk_sys_in),
	.rst_b_in(rst_b_in),
	.psel_in(psel_in),
	.penable_in(penable_in),
	.pwrite_in(pwrite_in),
	.paddr_in(paddr_in),
	.pwdata_in(pwdata_in),
	.prdata_out(prdata_out),
	.pready_out(pready_out),
	.pslverr_out(pslverr_out),
	.timer_interrupt_indication_out(timer_interrupt_indication_out),
	.irq_out(irq_out)
);

// [bench/tb_gpdt_timer.sv]
`timescale 1ns/1ns
`include "gpdt_defs.svh"
module tb_gpdt_timer
	import gpdt_pkg::*;
;
	localparam logic [11:0] RL = 12'(4 * `GPDT_RELOAD_IDX);
	localparam logic [11:0] IS = 12'(4 * `GPDT_ISRC_IDX);
	localparam logic [11:0] CT = 12'(4 * `GPDT_CTL_IDX);
	localparam logic [11:0] MK = 12'(4 * `GPDT_IMASK_IDX);
	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h0;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] prdata_out;
	logic pready_out;
	logic pslverr_out;
	logic flag_out;
	logic irq_out;
	logic [31:0] rdat;
	logic rerr;
	int n_mismatch = 0;
	int n_checks = 0;
	// Short tick and settle counts keep the run small
	gpdt_timer #(.ADDR_W(12), .TICK_CYCLES(8), .SETTLE_CYCLES(5)) gpdt_timer_i (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.paddr_in(paddr_in),
		.pwdata_in(pwdata_in),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.timer_interrupt_indication_out(flag_out),
		.irq_out(irq_out)
	);
	always #4 clk_sys_in = ~clk_sys_in;
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys_in);
		// Look at registered outputs half a cycle later, once they have settled
		@(negedge clk_sys_in);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		do
			@(posedge clk_sys_in);
		while (pready_out !== 1'b1);
		rdat = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		wt(5000);
		n_mismatch++;
		end_sim();
	end
	initial
	begin
		repeat (10) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		rchk(RL, 32'hffff);
		chk(32'(rerr), 32'h0);
		chk(32'(pready_out), 32'h1);
		rchk(IS, 32'h0);
		rchk(CT, 32'h0);
		rchk(MK, 32'h0);
		rchk(12'h290, 32'h0);
		chk(32'(rerr), 32'h1);
		xfer(1'b1, RL, 32'h3);
		rchk(RL, 32'h3);
		xfer(1'b1, CT, 32'h1);
		wt(18);
		chk(32'(flag_out), 32'h0);
		wt(14);
		chk(32'(flag_out), 32'h1);
		chk(32'(irq_out), 32'h0);
		xfer(1'b1, MK, 32'h1);
		wt(1);
		chk(32'(irq_out), 32'h1);
		xfer(1'b1, IS, 32'h1);
		wt(1);
		chk(32'(flag_out), 32'h0);
		rchk(CT, 32'h81);
		wt(12);
		chk(32'(flag_out), 32'h1);
		xfer(1'b1, CT, 32'h0);
		xfer(1'b1, IS, 32'h1);
		// Reset with enable held, then pause part way through the count
		xfer(1'b1, RL, 32'h8);
		xfer(1'b1, CT, 32'h3);
		rchk(CT, 32'h3);
		wt(12);
		rchk(CT, 32'h81);
		wt(30);
		xfer(1'b1, CT, 32'h0);
		wt(100);
		chk(32'(flag_out), 32'h0);
		rchk(CT, 32'h0);
		xfer(1'b1, CT, 32'h1);
		wt(44);
		chk(32'(flag_out), 32'h1);
		xfer(1'b1, CT, 32'h0);
		xfer(1'b1, IS, 32'h1);
		xfer(1'b1, RL, 32'h2);
		xfer(1'b1, CT, 32'h5);
		wt(4);
		repeat (20)
		begin
			xfer(1'b0, CT, 32'h0);
			if (rdat[7] === 1'b0)
				break;
		end
		chk(rdat, 32'h4);
		chk(32'(flag_out), 32'h1);
		xfer(1'b1, IS, 32'h1);
		wt(100);
		chk(32'(flag_out), 32'h0);
		rchk(CT, 32'h4);
		end_sim();
	end
endmodule
